// ==== src/spa_top.sv ====
// Operation
// RULE1 - Boxcar filter averages blocks of two to the exponent, exponent 1 to 16.
// RULE2 - Accumulator clears after each completed block.
// RULE3 - Averaging active only for format 0x3 with exponent 1 to 16.
// RULE4 - Averaging word is 32 bits, low 30 carry the block average.
// RULE5 - Constant input block gives average whose top 24 bits equal the code.
// RULE6 - Bit 30 is overrange, high if any sample in the block saturated.
// RULE7 - Bit 31 is sync, high for one conversion per block at update.
// RULE8 - Average rate is conversion rate over two to exponent; exponent resets 0.
// RULE9 - Each channel adds its own signed 24-bit offset, reset zero.
// RULE10 - Each channel multiplies by unsigned 16-bit gain over 0x8000, reset 0x8000.
// RULE11 - Processed difference code clamps to 0x7FFFFF and 0x800000.
// RULE12 - Format 0x4 outputs the stored test pattern on both channels.
// RULE13 - Test pattern is shared and resets to 0x5A5A0F0F.
// RULE14 - One format setting applies to both channels.
// RULE15 - Formats 0x1, 0x2 append 8-bit common-mode code untouched by offset, gain.
// RULE16 - Difference codes are two's complement.
// RULE17 - Averager takes codes after offset, gain and clamping.
`timescale 1ns/10ps
`default_nettype none

module spa_top
(
	input  wire logic        CLK_I,         // 125 MHz clock
	input  wire logic        RST_N_I,       // Synchronous reset, active low
	input  wire logic        PSEL_I,        // APB select
	input  wire logic        PENABLE_I,     // APB access phase
	input  wire logic        PWRITE_I,      // APB write
	input  wire logic [7:0]  PADDR_I,       // APB byte address
	input  wire logic [31:0] PWDATA_I,      // APB write data
	output logic [31:0]      PRDATA_O,      // APB read data
	output logic             PREADY_O,      // APB ready
	output logic             PSLVERR_O,     // APB error
	input  wire logic        CNV_DONE_I,    // Conversion result valid pulse
	input  wire logic [23:0] CH0_DIFF_I,    // Channel 0 difference code
	input  wire logic [7:0]  CH0_CM_I,      // Channel 0 common-mode code
	input  wire logic [23:0] CH1_DIFF_I,    // Channel 1 difference code
	input  wire logic [7:0]  CH1_CM_I,      // Channel 1 common-mode code
	output logic [31:0]      CH0_DATA_O,    // Channel 0 output word
	output logic [31:0]      CH1_DATA_O,    // Channel 1 output word
	output logic             DATA_VALID_O,  // Output words updated pulse
	output logic             IRQ_O          // Interrupt level
);

	// ==========================================================
	// Functions

	// Offset, gain and clamp; returns {saturated, code}
	function automatic logic [24:0] proc_code(input logic [23:0] diff,
		input logic [23:0] ofs, input logic [15:0] gain);
		logic signed [24:0] sum;
		logic signed [41:0] prod;
		logic signed [26:0] scaled;
		sum = $signed({diff[23], diff}) + $signed({ofs[23], ofs}); // RULE9 RULE16
		prod = sum * $signed({1'b0, gain}); // RULE10
		scaled = prod[41:spa_pkg::GAIN_SHIFT];
		if (scaled > $signed({3'b000, spa_pkg::SAT_MAX})) // RULE11
			proc_code = {1'b1, spa_pkg::SAT_MAX};
		else if (scaled < $signed({3'b111, spa_pkg::SAT_MIN}))
			proc_code = {1'b1, spa_pkg::SAT_MIN};
		else
			proc_code = {1'b0, scaled[23:0]};
	endfunction

	// Block sum to 30-bit average, 6 fraction bits below the 24-bit code
	function automatic logic [29:0] avg30(input logic [39:0] sum, input logic [4:0] n);
		logic signed [45:0] w;
		w = $signed({sum, 6'h00});
		w = w >>> n; // RULE5
		avg30 = w[29:0];
	endfunction

	// ==========================================================
	// Registers
	logic [2:0]  fmt;
	logic [4:0]  avg_exp;
	logic [23:0] ofs [2];
	logic [15:0] gain [2];
	logic [31:0] pattern;
	logic [2:0]  irq_status;
	logic [2:0]  irq_enable;
	logic [15:0] blk_cnt;
	logic [39:0] acc [2];
	logic [1:0]  ovr_acc;
	logic [31:0] data_word [2];
	logic [29:0] avg_hold [2];
	logic [1:0]  ovr_hold;

	logic        wr_en;
	logic        setup;
	logic        cfg_wr;
	logic [2:0]  clr_mask;
	logic        avg_on;
	logic        blk_last;
	logic [24:0] proc [2];
	logic [23:0] diff_in [2];
	logic [7:0]  cm_in [2];
	logic [39:0] next_sum [2];
	logic [2:0]  irq_events;

	assign diff_in[0] = CH0_DIFF_I;
	assign diff_in[1] = CH1_DIFF_I;
	assign cm_in[0]   = CH0_CM_I;
	assign cm_in[1]   = CH1_CM_I;

	// ==========================================================
	// APB slave
	// No wait state: read data is captured in the setup cycle
	assign PREADY_O = PSEL_I & PENABLE_I;
	assign setup    = PSEL_I & ~PENABLE_I;
	assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
	assign cfg_wr   = wr_en & ((PADDR_I == spa_pkg::ADDR_MODE) | (PADDR_I == spa_pkg::ADDR_AVG));
	assign clr_mask = (wr_en && PADDR_I == spa_pkg::ADDR_CLEAR) ? PWDATA_I[2:0] : 3'h0;

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			fmt     <= spa_pkg::FMT_RESET;
			avg_exp <= spa_pkg::EXP_RESET; // RULE8
			ofs[0]  <= spa_pkg::OFS_RESET; // RULE9
			ofs[1]  <= spa_pkg::OFS_RESET;
			gain[0] <= spa_pkg::GAIN_RESET; // RULE10
			gain[1] <= spa_pkg::GAIN_RESET;
			pattern <= spa_pkg::PATTERN_RESET; // RULE13
			irq_enable <= 3'h0;
		end
		else if (wr_en)
		begin
			unique case (PADDR_I)
				spa_pkg::ADDR_MODE:    fmt     <= PWDATA_I[2:0]; // RULE14
				spa_pkg::ADDR_AVG:     avg_exp <= PWDATA_I[4:0];
				spa_pkg::ADDR_OFS0:    ofs[0]  <= PWDATA_I[23:0];
				spa_pkg::ADDR_OFS1:    ofs[1]  <= PWDATA_I[23:0];
				spa_pkg::ADDR_GAIN0:   gain[0] <= PWDATA_I[15:0];
				spa_pkg::ADDR_GAIN1:   gain[1] <= PWDATA_I[15:0];
				spa_pkg::ADDR_PATTERN: pattern <= PWDATA_I;
				spa_pkg::ADDR_ENABLE:  irq_enable <= PWDATA_I[2:0];
				default:               ;
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			PRDATA_O  <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end
		else if (setup)
		begin
			PSLVERR_O <= 1'b0;
			unique case (PADDR_I)
				spa_pkg::ADDR_MODE:    PRDATA_O <= {29'h0, fmt};
				spa_pkg::ADDR_AVG:     PRDATA_O <= {27'h0, avg_exp};
				spa_pkg::ADDR_OFS0:    PRDATA_O <= {8'h00, ofs[0]};
				spa_pkg::ADDR_OFS1:    PRDATA_O <= {8'h00, ofs[1]};
				spa_pkg::ADDR_GAIN0:   PRDATA_O <= {16'h0000, gain[0]};
				spa_pkg::ADDR_GAIN1:   PRDATA_O <= {16'h0000, gain[1]};
				spa_pkg::ADDR_PATTERN: PRDATA_O <= pattern;
				spa_pkg::ADDR_STATUS:  PRDATA_O <= {29'h0, irq_status};
				spa_pkg::ADDR_ENABLE:  PRDATA_O <= {29'h0, irq_enable};
				spa_pkg::ADDR_CLEAR:   PRDATA_O <= 32'h00000000;
				spa_pkg::ADDR_DATA0:   PRDATA_O <= data_word[0];
				spa_pkg::ADDR_DATA1:   PRDATA_O <= data_word[1];
				spa_pkg::ADDR_BLKCNT:  PRDATA_O <= {16'h0000, blk_cnt};
				default:
				begin
					PRDATA_O  <= 32'h00000000;
					PSLVERR_O <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// Sample processing
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			proc[c] = proc_code(diff_in[c], ofs[c], gain[c]); // RULE17
			next_sum[c] = acc[c] + {{16{proc[c][23]}}, proc[c][23:0]};
		end
	end

	assign avg_on = (fmt == spa_pkg::FMT_AVERAGE) && (avg_exp >= spa_pkg::EXP_MIN)
		&& (avg_exp <= spa_pkg::EXP_MAX); // RULE3
	assign blk_last = ({1'b0, blk_cnt} == ((17'h00001 << avg_exp) - 17'h00001)); // RULE1

	// ==========================================================
	// Boxcar filter
	// A mode or exponent write restarts the block so no block mixes modes or exponents
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I || !avg_on || cfg_wr)
		begin
			blk_cnt <= 16'h0000;
			acc[0]  <= 40'h0;
			acc[1]  <= 40'h0;
			ovr_acc <= 2'b00;
		end
		else if (CNV_DONE_I)
		begin
			if (blk_last)
			begin
				blk_cnt <= 16'h0000; // RULE2
				acc[0]  <= 40'h0;
				acc[1]  <= 40'h0;
				ovr_acc <= 2'b00;
			end
			else
			begin
				blk_cnt <= blk_cnt + 16'h0001;
				acc[0]  <= next_sum[0];
				acc[1]  <= next_sum[1];
				ovr_acc <= ovr_acc | {proc[1][24], proc[0][24]}; // RULE6
			end
		end
	end

	// Last completed average, reported with sync low between updates
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			avg_hold[0] <= 30'h0;
			avg_hold[1] <= 30'h0;
			ovr_hold    <= 2'b00;
		end
		else if (CNV_DONE_I && avg_on && !cfg_wr && blk_last)
		begin
			avg_hold[0] <= avg30(next_sum[0], avg_exp); // RULE8
			avg_hold[1] <= avg30(next_sum[1], avg_exp);
			ovr_hold    <= ovr_acc | {proc[1][24], proc[0][24]};
		end
	end

	// ==========================================================
	// Output formatting
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			data_word[0] <= 32'h00000000;
			data_word[1] <= 32'h00000000;
		end
		else if (CNV_DONE_I)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (avg_on)
				begin
					if (!cfg_wr && blk_last)
						data_word[c] <= {1'b1, ovr_acc[c] | proc[c][24],
							avg30(next_sum[c], avg_exp)}; // RULE4 RULE7
					else
						data_word[c] <= {1'b0, ovr_hold[c], avg_hold[c]};
				end
				else if (fmt == spa_pkg::FMT_PATTERN)
					data_word[c] <= pattern; // RULE12
				else if (fmt == spa_pkg::FMT_DIFF16CM)
					data_word[c] <= {8'h00, proc[c][23:8], cm_in[c]}; // RULE15
				else if (fmt == spa_pkg::FMT_DIFF24CM)
					data_word[c] <= {proc[c][23:0], cm_in[c]};
				else
					data_word[c] <= {{8{proc[c][23]}}, proc[c][23:0]};
			end
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			DATA_VALID_O <= 1'b0;
		else
			DATA_VALID_O <= CNV_DONE_I;
	end

	assign CH0_DATA_O = data_word[0];
	assign CH1_DATA_O = data_word[1];

	// ==========================================================
	// Interrupts
	// Set wins over a clear in the same cycle
	assign irq_events[spa_pkg::IRQ_SAMPLE] = CNV_DONE_I;
	assign irq_events[spa_pkg::IRQ_BLOCK]  = CNV_DONE_I & avg_on & ~cfg_wr & blk_last;
	assign irq_events[spa_pkg::IRQ_OVER]   = CNV_DONE_I & (proc[0][24] | proc[1][24]);

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			irq_status <= 3'h0;
		else
			irq_status <= (irq_status & ~clr_mask) | irq_events;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(((irq_status & ~clr_mask) | irq_events) & irq_enable);
	end

endmodule

`default_nettype wire

// ==== src/spa_pkg.sv ====
package spa_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_AVG      = 8'h04;
	localparam logic [7:0] ADDR_OFS0     = 8'h08;
	localparam logic [7:0] ADDR_OFS1     = 8'h0C;
	localparam logic [7:0] ADDR_GAIN0    = 8'h10;
	localparam logic [7:0] ADDR_GAIN1    = 8'h14;
	localparam logic [7:0] ADDR_PATTERN  = 8'h18;
	localparam logic [7:0] ADDR_STATUS   = 8'h1C;
	localparam logic [7:0] ADDR_ENABLE   = 8'h20;
	localparam logic [7:0] ADDR_CLEAR    = 8'h24;
	localparam logic [7:0] ADDR_DATA0    = 8'h28;
	localparam logic [7:0] ADDR_DATA1    = 8'h2C;
	localparam logic [7:0] ADDR_BLKCNT   = 8'h30;

	// ==========================================================
	// Field widths and reset values
	localparam int FMT_W  = 3;
	localparam int EXP_W  = 5;
	localparam int IRQ_W  = 3;
	localparam logic [2:0]  FMT_RESET     = 3'h0;
	localparam logic [4:0]  EXP_RESET     = 5'h00;
	localparam logic [4:0]  EXP_MIN       = 5'h01;
	localparam logic [4:0]  EXP_MAX       = 5'h10;
	localparam logic [23:0] OFS_RESET     = 24'h000000;
	localparam logic [15:0] GAIN_RESET    = 16'h8000;
	localparam int          GAIN_SHIFT    = 15;
	localparam logic [31:0] PATTERN_RESET = 32'h5A5A0F0F;
	localparam logic [23:0] SAT_MAX       = 24'h7FFFFF;
	localparam logic [23:0] SAT_MIN       = 24'h800000;
	localparam int          AVG_FRAC      = 6;

	// ==========================================================
	// Interrupt bit positions
	localparam int IRQ_SAMPLE = 0;
	localparam int IRQ_BLOCK  = 1;
	localparam int IRQ_OVER   = 2;

	// ==========================================================
	// Output formats
	typedef enum logic [2:0] {
		FMT_DIFF24   = 3'b000,
		FMT_DIFF16CM = 3'b001,
		FMT_DIFF24CM = 3'b010,
		FMT_AVERAGE  = 3'b011,
		FMT_PATTERN  = 3'b100
	} spa_fmt_t;

endpackage

// ==== test/spa_checker_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module spa_checker
(
	input wire logic        CLK_I,        // Clock
	input wire logic        RST_N_I,      // Reset
	input wire logic        PSEL_I,       // Select
	input wire logic        PENABLE_I,    // Access
	input wire logic        PWRITE_I,     // Write
	input wire logic [7:0]  PADDR_I,      // Address
	input wire logic [31:0] PWDATA_I,     // Write data
	input wire logic        PSLVERR_O,    // Error
	input wire logic        CNV_DONE_I,   // Conversion
	input wire logic [7:0]  CH0_CM_I,     // Common mode
	input wire logic [31:0] CH0_DATA_O,   // Word 0
	input wire logic [31:0] CH1_DATA_O,   // Word 1
	input wire logic        DATA_VALID_O  // Valid
);
	// ==========================================
	// Mode shadow
	logic [2:0] fmt;
	logic [4:0] ex;
	logic       avg;
	assign avg = fmt == 3'h3 && ex != 5'h00 && ex <= 5'h10;
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			fmt <= 3'h0;
			ex <= 5'h00;
		end
		else if (PSEL_I && PENABLE_I && PWRITE_I)
		begin
			if (PADDR_I == 8'h00)
				fmt <= PWDATA_I[2:0];
			if (PADDR_I == 8'h04)
				ex <= PWDATA_I[4:0];
		end
	end
	// ==========================================
	// Properties
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_sync; CNV_DONE_I && avg && CH0_DATA_O[31]; endsequence
	property p_sync; s_sync |=> !CH0_DATA_O[31]; endproperty
	a_sync: assert property (p_sync) else $error("sync twice");
	property p_valid; CNV_DONE_I |=> DATA_VALID_O; endproperty
	a_valid: assert property (p_valid) else $error("no valid");
	property p_novalid; !CNV_DONE_I |=> !DATA_VALID_O; endproperty
	a_novalid: assert property (p_novalid) else $error("stray valid");
	property p_hold; !CNV_DONE_I |=> $stable(CH0_DATA_O) && $stable(CH1_DATA_O); endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	property p_err; PSEL_I && PENABLE_I && PADDR_I > 8'h30 |-> PSLVERR_O; endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_pat; DATA_VALID_O && fmt == 3'h4 |-> CH0_DATA_O == CH1_DATA_O; endproperty
	a_pat: assert property (p_pat) else $error("pattern differs");
	property p_cm; DATA_VALID_O && fmt == 3'h2 |-> CH0_DATA_O[7:0] == $past(CH0_CM_I); endproperty
	a_cm: assert property (p_cm) else $error("cm lost");
	property p_f1; DATA_VALID_O && fmt == 3'h1 |-> CH0_DATA_O[31:24] == 8'h00; endproperty
	a_f1: assert property (p_f1) else $error("top byte");
endmodule

bind spa_top spa_checker spa_checker_i
(
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSLVERR_O(PSLVERR_O),
	.CNV_DONE_I(CNV_DONE_I), .CH0_CM_I(CH0_CM_I), .CH0_DATA_O(CH0_DATA_O),
	.CH1_DATA_O(CH1_DATA_O), .DATA_VALID_O(DATA_VALID_O)
);
`default_nettype wire

// ==== test/spa_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module spa_host_model
(
	input  wire logic        clk_i,   // Clock
	input  wire logic        valid_i, // Word strobe
	input  wire logic [31:0] ch0_i,   // Word 0
	input  wire logic [31:0] ch1_i,   // Word 1
	output logic             got_o,   // Capture pulse
	output logic [63:0]      word_o   // Captured pair
);
	// Reader latches both lanes on every clock; got_o follows the strobe one cycle later
	always_ff @(posedge clk_i)
	begin
		got_o <= valid_i;
		word_o <= {ch1_i, ch0_i};
	end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, cnv = 1'b0;
	logic [7:0]  paddr = 8'h00, cm0 = 8'h00, cm1 = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, d0o, d1o, rd, pat = 32'h5A5A0F0F;
	logic [23:0] df0 = 24'h0, df1 = 24'h0, v, ofs[2] = '{24'h0, 24'h0};
	logic [15:0] gn[2] = '{16'h8000, 16'h8000};
	logic        pready, pslverr, dvalid, irq, got, er, orr[2], ol[2] = '{1'b0, 1'b0};
	logic [63:0] word, expq[$];
	logic [2:0]  fmt = 3'h0;
	logic [4:0]  nx = 5'h00;
	logic [29:0] av[2] = '{30'h0, 30'h0};
	longint      sum[2];
	int          n_mismatch = 0, samples_checked = 0, cyc = 0, cnt = 0;

	always #4 clk = ~clk;
	spa_top spa_top_i (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .CNV_DONE_I(cnv), .CH0_DIFF_I(df0),
		.CH0_CM_I(cm0), .CH1_DIFF_I(df1), .CH1_CM_I(cm1), .CH0_DATA_O(d0o),
		.CH1_DATA_O(d1o), .DATA_VALID_O(dvalid), .IRQ_O(irq));
	spa_host_model spa_host_model_i (.clk_i(clk), .valid_i(dvalid), .ch0_i(d0o),
		.ch1_i(d1o), .got_o(got), .word_o(word));

	task check(input logic [63:0] seen, input logic [63:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
		end
	endtask

	task tally_and_finish;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] want, input logic ew);
		apb(1'b0, a, 32'h0);
		check({er, rd}, {ew, want});
	endtask

	task cfg(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		cnt = 0;
		sum = '{0, 0};
		orr = '{1'b0, 1'b0};
		case (a)
			spa_pkg::ADDR_MODE: fmt = d[2:0];
			spa_pkg::ADDR_AVG: nx = d[4:0];
			spa_pkg::ADDR_OFS0: ofs[0] = d[23:0];
			spa_pkg::ADDR_OFS1: ofs[1] = d[23:0];
			spa_pkg::ADDR_GAIN0: gn[0] = d[15:0];
			spa_pkg::ADDR_GAIN1: gn[1] = d[15:0];
			spa_pkg::ADDR_PATTERN: pat = d;
			default: ;
		endcase
	endtask

	function automatic logic [24:0] proc(input logic [23:0] d, o, input logic [15:0] g);
		longint x;
		x = ((longint'($signed(d)) + longint'($signed(o))) * longint'(g)) >>> 15;
		if (x > 64'sd8388607)
			return {1'b1, spa_pkg::SAT_MAX};
		if (x < -64'sd8388608)
			return {1'b1, spa_pkg::SAT_MIN};
		return {1'b0, x[23:0]};
	endfunction

	task conv(input logic [23:0] a0, a1, input logic [7:0] c0, c1);
		logic [24:0] p;
		logic [31:0] w[2];
		for (int i = 0; i < 2; i++)
		begin
			p = proc(i ? a1 : a0, ofs[i], gn[i]);
			case (fmt)
				3'h1: w[i] = {8'h00, p[23:8], i ? c1 : c0};
				3'h2: w[i] = {p[23:0], i ? c1 : c0};
				3'h4: w[i] = pat;
				default: w[i] = {{8{p[23]}}, p[23:0]};
			endcase
			if (fmt == 3'h3)
			begin
				sum[i] += longint'($signed(p[23:0]));
				orr[i] |= p[24];
				if (cnt + 1 == (1 << nx))
				begin
					av[i] = 30'((sum[i] <<< 6) >>> nx);
					ol[i] = orr[i];
					sum[i] = 0;
					orr[i] = 1'b0;
				end
				w[i] = {cnt + 1 == (1 << nx), ol[i], av[i]};
			end
		end
		cnt = (cnt + 1 == (1 << nx)) ? 0 : cnt + 1;
		expq.push_back({w[1], w[0]});
		@(posedge clk);
		cnv <= 1'b1;
		{df0, df1, cm0, cm1} <= {a0, a1, c0, c1};
		@(posedge clk);
		cnv <= 1'b0;
	endtask

	always @(posedge clk)
		if (got === 1'b1)
			check(word, expq.pop_front());

	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	end

	initial
	begin
		void'($urandom(45));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(spa_pkg::ADDR_AVG, 32'h0, 1'b0);
		rdchk(spa_pkg::ADDR_OFS1, 32'h0, 1'b0);
		rdchk(spa_pkg::ADDR_GAIN0, 32'h8000, 1'b0);
		rdchk(spa_pkg::ADDR_PATTERN, 32'h5A5A0F0F, 1'b0);
		rdchk(8'h40, 32'h0, 1'b1);
		// Lane 1 near double gain so blocks clamp
		cfg(spa_pkg::ADDR_GAIN1, 32'hFFFF);
		cfg(spa_pkg::ADDR_AVG, 32'h2);
		cfg(spa_pkg::ADDR_MODE, 32'h3);
		v = 24'($urandom);
		repeat (4) conv(v, v, 8'h00, 8'h00);
		repeat (4) conv(24'($urandom), 24'($urandom), 8'h00, 8'h00);
		cfg(spa_pkg::ADDR_OFS0, $urandom);
		cfg(spa_pkg::ADDR_OFS1, $urandom);
		cfg(spa_pkg::ADDR_GAIN0, $urandom);
		cfg(spa_pkg::ADDR_PATTERN, $urandom);
		for (int f = 0; f < 5; f++)
		begin
			cfg(spa_pkg::ADDR_MODE, 32'(f == 3 ? 0 : f));
			repeat (3) conv(24'($urandom), 24'($urandom), 8'($urandom), 8'($urandom));
		end
		cfg(spa_pkg::ADDR_ENABLE, 32'h0);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		cfg(spa_pkg::ADDR_ENABLE, 32'h1);
		repeat (2) @(posedge clk);
		check(irq, 1'b1);
		cfg(spa_pkg::ADDR_CLEAR, 32'h7);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		rdchk(spa_pkg::ADDR_STATUS, 32'h0, 1'b0);
		rdchk(spa_pkg::ADDR_DATA1, pat, 1'b0);
		// Every noted word must have been seen by the reader
		check(64'(expq.size()), 64'h0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
